/* File: logic/pcr_regs.v */
// page-0 register bank: page select, event counters, coding sublayer config
// assumes event inputs are already synchronous to ref_clk; link inputs are pins
`timescale 1ns/1ps
`default_nettype none
`include "pcr_map.vh"
module pcr_regs (
  input wire ref_clk,
  input wire reset_n,
  input wire [4:0] mgmt_addr,
  input wire [15:0] mgmt_wdata,
  input wire mgmt_wr,
  input wire mgmt_rd,
  output reg [15:0] mgmt_rdata,
  input wire false_carrier_event,
  input wire carrier_valid,
  input wire invalid_symbol,
  input wire collision,
  input wire signal_level_pin,
  input wire descrambler_lock_pin,
  output wire rx_clk_free_run,
  output wire true_quiet_enable,
  output wire force_signal_detect,
  output reg link_up,
  output wire [2:0] page_selector,
  output wire sel_ext_page0,
  output wire sel_link_diag,
  output wire sel_ptp_base,
  output wire sel_ptp_config,
  output wire rx_error_half_full_flag,
  output wire irq
);

  reg [2:0] page_reg;
  reg [7:0] false_carrier_tally_reg;
  reg [7:0] receive_error_tally_reg;
  reg [15:0] cfg_reg;
  reg [2:0] irq_status_reg;
  reg [2:0] irq_mask_reg;
  reg carrier_hit_reg;
  reg carrier_prev_reg;
  reg sig_meta_reg, sig_sync_reg, lock_meta_reg, lock_sync_reg;
  reg link_prev_reg;
  wire link_next;
  wire signal_ok;
  wire paged_hit;
  wire rd_false_carrier;
  wire rd_rx_error;
  wire rd_status;
  wire fc_half_event;
  wire rx_half_event;
  wire rx_count_event;
  wire [2:0] irq_events;

  // saturating increment shared by both tallies
  function [7:0] sat_inc;
    input [7:0] value;
    begin
      if (value == `PCR_CNT_MAX) begin
        sat_inc = value;
      end else begin
        sat_inc = value + 8'h01;
      end
    end
  endfunction

  // paged registers answer only while page 0 is selected
  assign paged_hit = (mgmt_addr >= `PCR_PAGED_BASE) && (page_reg == `PCR_PAGE_EXT0);
  assign rd_false_carrier = mgmt_rd && paged_hit && (mgmt_addr == `PCR_ADDR_FALSE_CARRIER);
  assign rd_rx_error = mgmt_rd && paged_hit && (mgmt_addr == `PCR_ADDR_RX_ERROR);
  assign rd_status = mgmt_rd && paged_hit && (mgmt_addr == `PCR_ADDR_IRQ_STATUS);

  assign page_selector = page_reg;
  assign sel_ext_page0 = (page_reg == `PCR_PAGE_EXT0);
  assign sel_link_diag = (page_reg == `PCR_PAGE_DIAG);
  assign sel_ptp_base = (page_reg == `PCR_PAGE_PTP_BASE);
  assign sel_ptp_config = (page_reg == `PCR_PAGE_PTP_CFG5) ||
                          (page_reg == `PCR_PAGE_PTP_CFG6);

  assign rx_clk_free_run = cfg_reg[`PCR_BIT_FREE_CLK];
  assign true_quiet_enable = cfg_reg[`PCR_BIT_TRUE_QUIET];
  assign force_signal_detect = cfg_reg[`PCR_BIT_FORCE_SD];

  // level pins pass two flops before use
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sig_meta_reg <= 1'b0;
      sig_sync_reg <= 1'b0;
      lock_meta_reg <= 1'b0;
      lock_sync_reg <= 1'b0;
    end else begin
      sig_meta_reg <= signal_level_pin;
      sig_sync_reg <= sig_meta_reg;
      lock_meta_reg <= descrambler_lock_pin;
      lock_sync_reg <= lock_meta_reg;
    end
  end

  assign signal_ok = sig_sync_reg || force_signal_detect;
  // link needs both to come up; hold policy chosen by bit 8
  assign link_next = !link_up ? (signal_ok && lock_sync_reg) :
                     cfg_reg[`PCR_BIT_LINK_HOLD] ? signal_ok :
                     (signal_ok && lock_sync_reg);

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      link_up <= 1'b0;
      link_prev_reg <= 1'b0;
    end else begin
      link_up <= link_next;
      link_prev_reg <= link_up;
    end
  end

  // page and config writes
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      page_reg <= `PCR_PAGE_RESET;
      cfg_reg <= `PCR_CFG_RESET;
      irq_mask_reg <= 3'h0;
    end else if (mgmt_wr) begin
      if (mgmt_addr == `PCR_ADDR_PAGE) begin
        page_reg <= mgmt_wdata[2:0];
      end else if (paged_hit && mgmt_addr == `PCR_ADDR_CODING_CFG) begin
        // reserved top bits and bit 4 are forced to zero on the way in
        cfg_reg <= mgmt_wdata & `PCR_CFG_WMASK;
      end else if (paged_hit && mgmt_addr == `PCR_ADDR_IRQ_MASK) begin
        irq_mask_reg <= mgmt_wdata[2:0];
      end
    end
  end

  // false carrier tally; an event in the read cycle starts the new count at one
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      false_carrier_tally_reg <= 8'h00;
    end else if (rd_false_carrier) begin
      false_carrier_tally_reg <= false_carrier_event ? 8'h01 : 8'h00;
    end else if (false_carrier_event) begin
      false_carrier_tally_reg <= sat_inc(false_carrier_tally_reg);
    end
  end

  // receive error: remember a bad symbol, count at carrier end unless collided
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      carrier_hit_reg <= 1'b0;
      carrier_prev_reg <= 1'b0;
    end else begin
      carrier_prev_reg <= carrier_valid;
      if (!carrier_valid) begin
        carrier_hit_reg <= 1'b0;
      end else if (collision) begin
        carrier_hit_reg <= 1'b0;
      end else if (invalid_symbol && !carrier_hit_reg) begin
        carrier_hit_reg <= 1'b1;
      end
    end
  end

  // collision anywhere in the carrier blocks the count until carrier ends
  reg carrier_coll_reg;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      carrier_coll_reg <= 1'b0;
    end else if (!carrier_valid) begin
      carrier_coll_reg <= 1'b0;
    end else if (collision) begin
      carrier_coll_reg <= 1'b1;
    end
  end

  assign rx_count_event = carrier_prev_reg && !carrier_valid &&
                          carrier_hit_reg && !carrier_coll_reg;

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      receive_error_tally_reg <= 8'h00;
    end else if (rd_rx_error) begin
      receive_error_tally_reg <= rx_count_event ? 8'h01 : 8'h00;
    end else if (rx_count_event) begin
      receive_error_tally_reg <= sat_inc(receive_error_tally_reg);
    end
  end

  // half-full events fire once on the crossing into the upper half
  assign fc_half_event = false_carrier_event && !rd_false_carrier &&
                         (false_carrier_tally_reg == `PCR_CNT_HALF - 8'h01);
  assign rx_half_event = rx_count_event && !rd_rx_error &&
                         (receive_error_tally_reg == `PCR_CNT_HALF - 8'h01);
  assign irq_events = {link_up != link_prev_reg, rx_half_event, fc_half_event};

  // sticky status: set wins over a clear by read or write-one
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_status_reg <= 3'h0;
    end else begin
      if (rd_status) begin
        irq_status_reg[`PCR_IRQ_RX_HALF] <= 1'b0;
      end
      if (mgmt_wr && paged_hit && mgmt_addr == `PCR_ADDR_IRQ_STATUS) begin
        irq_status_reg <= (irq_status_reg & ~mgmt_wdata[2:0]) | irq_events;
      end else if (rd_status) begin
        irq_status_reg <= (irq_status_reg &
                           ~(3'h1 << `PCR_IRQ_RX_HALF)) | irq_events;
      end else begin
        irq_status_reg <= irq_status_reg | irq_events;
      end
    end
  end

  assign rx_error_half_full_flag = irq_status_reg[`PCR_IRQ_RX_HALF];
  assign irq = |(irq_status_reg & irq_mask_reg);

  // read data in the cycle after the strobe
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mgmt_rdata <= 16'h0000;
    end else if (mgmt_rd) begin
      if (mgmt_addr == `PCR_ADDR_PAGE) begin
        mgmt_rdata <= {13'h0000, page_reg};
      end else if (rd_false_carrier) begin
        mgmt_rdata <= {8'h00, false_carrier_tally_reg};
      end else if (rd_rx_error) begin
        mgmt_rdata <= {8'h00, receive_error_tally_reg};
      end else if (paged_hit && mgmt_addr == `PCR_ADDR_CODING_CFG) begin
        mgmt_rdata <= cfg_reg;
      end else if (rd_status) begin
        mgmt_rdata <= {13'h0000, irq_status_reg};
      end else if (paged_hit && mgmt_addr == `PCR_ADDR_IRQ_MASK) begin
        mgmt_rdata <= {13'h0000, irq_mask_reg};
      end else begin
        mgmt_rdata <= 16'h0000;
      end
    end else begin
      mgmt_rdata <= 16'h0000;
    end
  end

endmodule
`default_nettype wire

/* File: logic/pcr_map.vh */
// register map and field constants for the page-0 counter and coding config block
// assumes a 5-bit management address and 16-bit data words
`ifndef PCR_MAP_VH
`define PCR_MAP_VH
`define PCR_ADDR_PAGE 5'h13
`define PCR_ADDR_FALSE_CARRIER 5'h14
`define PCR_ADDR_RX_ERROR 5'h15
`define PCR_ADDR_CODING_CFG 5'h16
`define PCR_ADDR_IRQ_STATUS 5'h17
`define PCR_ADDR_IRQ_MASK 5'h18
`define PCR_PAGED_BASE 5'h14
`define PCR_PAGE_EXT0 3'h0
`define PCR_PAGE_DIAG 3'h2
`define PCR_PAGE_PTP_BASE 3'h4
`define PCR_PAGE_PTP_CFG5 3'h5
`define PCR_PAGE_PTP_CFG6 3'h6
`define PCR_PAGE_RESET 3'h0
`define PCR_CFG_RESET 16'h0100
`define PCR_CFG_WMASK 16'h0fef
`define PCR_BIT_FREE_CLK 11
`define PCR_BIT_TRUE_QUIET 10
`define PCR_BIT_FORCE_SD 9
`define PCR_BIT_LINK_HOLD 8
`define PCR_CNT_MAX 8'hff
`define PCR_CNT_HALF 8'h80
`define PCR_IRQ_FC_HALF 0
`define PCR_IRQ_RX_HALF 1
`define PCR_IRQ_LINK_CHG 2
`endif

/* File: verif/pcr_regs_checker.sv */
// checker for the page-0 register bank
// assumes it is bound to pcr_regs and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module pcr_checker (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [4:0] mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [15:0] mgmt_rdata,
  input wire logic false_carrier_event,
  input wire logic carrier_valid,
  input wire logic signal_level_pin,
  input wire logic rx_clk_free_run,
  input wire logic true_quiet_enable,
  input wire logic force_signal_detect,
  input wire logic link_up,
  input wire logic [2:0] page_selector,
  input wire logic sel_ext_page0,
  input wire logic sel_link_diag,
  input wire logic sel_ptp_base,
  input wire logic sel_ptp_config,
  input wire logic rx_error_half_full_flag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire p0 = page_selector == 3'h0;
  wire [2:0] cfg_w = mgmt_wdata[11:9];
  page_read_a: assert property (mgmt_rd && mgmt_addr == 5'h13
    |=> mgmt_rdata == {13'h0, $past(page_selector)}) else $error("page readback wrong");
  page_decode_a: assert property (sel_ext_page0 == p0
    && sel_link_diag == (page_selector == 3'h2) && sel_ptp_base == (page_selector == 3'h4)
    && sel_ptp_config == (page_selector inside {3'h5, 3'h6})) else $error("page decode wrong");
  counter_upper_a: assert property (mgmt_rd && p0 && mgmt_addr inside {5'h14, 5'h15}
    |=> mgmt_rdata[15:8] == 8'h0) else $error("counter upper bits set");
  paged_off_a: assert property (mgmt_rd && !p0 && mgmt_addr >= 5'h14
    |=> mgmt_rdata == 16'h0) else $error("paged address answered off page 0");
  cfg_outputs_a: assert property (mgmt_wr && p0 && mgmt_addr == 5'h16
    |=> {rx_clk_free_run, true_quiet_enable, force_signal_detect} == $past(cfg_w))
    else $error("config outputs do not follow write");
  read_clear_a: assert property (mgmt_rd && mgmt_addr == 5'h14 && p0
    && !false_carrier_event ##1 !false_carrier_event ##1 mgmt_rd && mgmt_addr == 5'h14
    && !false_carrier_event |=> mgmt_rdata == 16'h0) else $error("counter not cleared by read");
  link_drop_a: assert property ((!force_signal_detect && !signal_level_pin) [*4]
    |-> !link_up) else $error("link kept without signal");
  half_clear_a: assert property (mgmt_rd && mgmt_addr == 5'h17 && p0
    && !carrier_valid && !$past(carrier_valid) |=> !rx_error_half_full_flag)
    else $error("half-full flag survived read");
endmodule
bind pcr_regs pcr_checker i_chk (.*);
`default_nettype wire

/* File: verif/pcr_regs_bench.sv */
// self-checking bench for the page-0 register bank
// drives every pin itself; inputs change by nonblocking assignment at rising edges
`timescale 1ns/1ps
`default_nettype none
module pcr_regs_bench;
  logic ref_clk = 0, reset_n = 0, mgmt_wr = 0, mgmt_rd = 0;
  logic [4:0] mgmt_addr = 0;
  logic [15:0] mgmt_wdata = 0, mgmt_rdata;
  logic fce = 0, cv = 0, isym = 0, col = 0, sig = 0, lock = 0;
  logic free_run, quiet, force_sd, link_up, half, irq;
  logic [2:0] page;
  int fails = 0, total_checks = 0, cyc = 0;
  always #4 ref_clk = ~ref_clk;
  pcr_regs i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .mgmt_addr(mgmt_addr),
    .mgmt_wdata(mgmt_wdata), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_rdata(mgmt_rdata),
    .false_carrier_event(fce), .carrier_valid(cv), .invalid_symbol(isym), .collision(col),
    .signal_level_pin(sig), .descrambler_lock_pin(lock), .rx_clk_free_run(free_run),
    .true_quiet_enable(quiet), .force_signal_detect(force_sd), .link_up(link_up),
    .page_selector(page), .sel_ext_page0(), .sel_link_diag(), .sel_ptp_base(),
    .sel_ptp_config(), .rx_error_half_full_flag(half), .irq(irq));
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    mgmt_wr <= 1'b1;
    mgmt_addr <= a;
    mgmt_wdata <= d;
    @(posedge ref_clk) mgmt_wr <= 1'b0;
  endtask
  task rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    mgmt_rd <= 1'b1;
    mgmt_addr <= a;
    @(posedge ref_clk) mgmt_rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), exp, mgmt_rdata);
  endtask
  // one carrier with nbad invalid symbols, optionally under collision
  task frame(input int nbad, input logic c);
    @(posedge ref_clk);
    cv <= 1'b1;
    col <= c;
    repeat (nbad) begin
      @(posedge ref_clk) isym <= 1'b1;
      @(posedge ref_clk) isym <= 1'b0;
    end
    @(posedge ref_clk);
    cv <= 1'b0;
    col <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  // pins pass two sync flops plus the link register, so 5 cycles is ample
  task pins(input logic s, input logic l, input logic exp);
    @(posedge ref_clk);
    sig <= s;
    lock <= l;
    repeat (5) @(posedge ref_clk);
    #1 chk("link_up", {15'h0, exp}, {15'h0, link_up});
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      finish_test;
    end
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(5'h13, 16'h0000);
    rd(5'h16, 16'h0100);
    // a nonzero count first, so off-page reads of 0x14 neither answer nor clear it
    repeat (3) begin
      @(posedge ref_clk) fce <= 1'b1;
      @(posedge ref_clk) fce <= 1'b0;
    end
    for (int p = 1; p < 9; p++) begin
      wr(5'h13, {13'h1fff, p[2:0]});
      rd(5'h13, {13'h0, p[2:0]});
      rd(5'h14, (p == 8) ? 16'h0003 : 16'h0000);
    end
    wr(5'h13, 16'h0000);
    repeat (300) begin
      @(posedge ref_clk) fce <= 1'b1;
      @(posedge ref_clk) fce <= 1'b0;
    end
    wr(5'h14, 16'hffff);
    rd(5'h14, 16'h00ff);
    rd(5'h14, 16'h0000);
    rd(5'h1f, 16'h0000);
    chk("irq masked", 16'h0, {15'h0, irq});
    frame(3, 1'b0);
    frame(2, 1'b1);
    frame(0, 1'b0);
    rd(5'h15, 16'h0001);
    wr(5'h18, 16'h0002);
    repeat (300) frame(1, 1'b0);
    rd(5'h15, 16'h00ff);
    chk("irq", 16'h1, {15'h0, irq});
    rd(5'h17, 16'h0003);
    chk("half flag", 16'h0, {15'h0, half});
    chk("irq cleared", 16'h0, {15'h0, irq});
    wr(5'h17, 16'h0001);
    rd(5'h17, 16'h0000);
    wr(5'h16, 16'h0fff);
    rd(5'h16, 16'h0fef);
    chk("cfg pins", 16'h7, {13'h0, free_run, quiet, force_sd});
    pins(1'b0, 1'b1, 1'b1);
    wr(5'h16, 16'h0000);
    #1 chk("cfg pins", 16'h0, {13'h0, free_run, quiet, force_sd});
    pins(1'b0, 1'b1, 1'b0);
    pins(1'b1, 1'b1, 1'b1);
    pins(1'b1, 1'b0, 1'b0);
    wr(5'h16, 16'h0100);
    pins(1'b1, 1'b1, 1'b1);
    pins(1'b1, 1'b0, 1'b1);
    pins(1'b0, 1'b0, 1'b0);
    // a second reset mid-run must bring page and config back to their defaults
    wr(5'h16, 16'h0000);
    wr(5'h13, 16'h0005);
    @(posedge ref_clk) reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(5'h13, 16'h0000);
    rd(5'h16, 16'h0100);
    finish_test;
  end
endmodule
`default_nettype wire
